// file: rtl/adhp_pkg.sv
package adhp_pkg;
    localparam int          SECTOR_BYTES = 512;
    localparam int          SECTOR_WORDS = SECTOR_BYTES / 2;
    localparam int          PTR_W        = 8;
    localparam logic [2:0]  ADDR_DATA    = 3'h0;
    localparam logic [2:0]  ADDR_STATUS  = 3'h7;
    localparam logic [2:0]  ADDR_ALT     = 3'h6;
    localparam logic [7:0]  STAT_RESET   = 8'h50;
    localparam int          STAT_DRQ_BIT = 3;
    localparam int          CTL_NIEN_BIT = 1;
    localparam int          CTL_SRST_BIT = 2;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [15:0] ZERO16       = 16'h0000;
    typedef enum logic [1:0] {ADHP_IDLE, ADHP_PIO, ADHP_DMA} adhp_mode_t;
endpackage : adhp_pkg

// file: rtl/adhp_host_port.sv
`timescale 1ns/1ps
// Operation
// - Three address bits select one of eight registers
// - Chip select 0 task file, 1 control
// - Cable select grounded master, open slave
// - Register access byte wide, data sixteen bits
// - Raise DMA request, host acknowledges active low
// - Data held in 512-byte sectors
// - Drive disk-active/slave-present line in handshake
// - Capture write data on write strobe rise
// - Interrupt request when service needed
// - Drive 16-bit indication during word transfers
module adhp_host_port (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hostReset_n,
    input  wire logic [2:0]  devAddr,
    input  wire logic        chipSel0_n,
    input  wire logic        chipSel1_n,
    input  wire logic        ioWrite_n,
    input  wire logic        ioRead_n,
    input  wire logic        dmaAck_n,
    input  wire logic        cableSel,
    input  wire logic [15:0] dataIn,
    output logic [15:0]      dataOut,
    output logic             dataOe,
    output logic             dmaReq,
    output logic             intReq,
    output logic             word16_n,
    output logic             diskActive_n_out,
    output logic             diskActive_n_oe,
    output logic             isMaster,
    input  wire logic        dmaStart,
    input  wire logic        dmaDir
);
    logic [7:0]              taskFile [0:7];
    logic [7:0]              devCtl;
    logic [15:0]             sector [0:adhp_pkg::SECTOR_WORDS-1];
    logic [adhp_pkg::PTR_W-1:0] wordPtr;
    logic                    wrPrev;
    logic                    rdPrev;
    logic                    pendIrq;
    logic                    strapDone;
    adhp_pkg::adhp_mode_t    mode;
    logic                    anyReset;
    logic                    wrRise;
    logic                    rdFall;
    logic                    rdRise;
    logic                    tfSel;
    logic                    ctlSel;
    logic                    dataAcc;
    logic                    cmdWr;
    logic                    statusRd;
    logic                    regWr;
    logic                    ctlWr;
    logic                    xferStep;
    logic                    lastWord;
    logic                    storeWord;

    function automatic logic isData(input logic cs0n, input logic [2:0] a);
        return !cs0n && a == adhp_pkg::ADDR_DATA;
    endfunction : isData

    function automatic logic isStatus(input logic cs0n, input logic cs1n, input logic [2:0] a);
        return !cs0n && cs1n && a == adhp_pkg::ADDR_STATUS;
    endfunction : isStatus

    function automatic logic isLast(input logic [adhp_pkg::PTR_W-1:0] ptr);
        return ptr == adhp_pkg::PTR_W'(adhp_pkg::SECTOR_WORDS - 1);
    endfunction : isLast

    assign anyReset = reset || !hostReset_n || devCtl[adhp_pkg::CTL_SRST_BIT];
    assign wrRise   = !wrPrev && ioWrite_n;
    assign rdFall   = rdPrev && !ioRead_n;
    assign rdRise   = !rdPrev && ioRead_n;
    assign tfSel    = !chipSel0_n && chipSel1_n;
    assign ctlSel   = chipSel0_n && !chipSel1_n && devAddr == adhp_pkg::ADDR_ALT;
    assign dataAcc  = (isData(chipSel0_n, devAddr) && chipSel1_n) || (mode == adhp_pkg::ADHP_DMA && !dmaAck_n);
    // Command register is write only
    assign cmdWr    = wrRise && isStatus(chipSel0_n, chipSel1_n, devAddr);
    assign statusRd = rdFall && isStatus(chipSel0_n, chipSel1_n, devAddr);
    assign regWr    = wrRise && tfSel && devAddr != adhp_pkg::ADDR_DATA && devAddr != adhp_pkg::ADDR_STATUS;
    assign ctlWr    = wrRise && ctlSel;
    assign xferStep = mode != adhp_pkg::ADHP_IDLE && dataAcc && (wrRise || rdRise);
    assign lastWord = isLast(wordPtr);
    assign storeWord = xferStep && wrRise && !dmaDir;

    // Strobe edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            wrPrev <= 1'b1;
            rdPrev <= 1'b1;
        end else begin
            wrPrev <= ioWrite_n;
            rdPrev <= ioRead_n;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            isMaster  <= 1'b0;
            strapDone <= 1'b0;
        end else if (!strapDone) begin
            isMaster  <= !cableSel;
            strapDone <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !hostReset_n) begin
            devCtl <= adhp_pkg::CTL_RESET;
        end else if (ctlWr) begin
            devCtl <= dataIn[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (anyReset) begin
            for (int i = 0; i < 8; i++) begin
                taskFile[i] <= 8'h00;
            end
            taskFile[adhp_pkg::ADDR_STATUS] <= adhp_pkg::STAT_RESET;
        end else begin
            if (regWr) begin
                taskFile[devAddr] <= dataIn[7:0];
            end
            taskFile[adhp_pkg::ADDR_STATUS][adhp_pkg::STAT_DRQ_BIT] <= mode != adhp_pkg::ADHP_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (anyReset) begin
            mode    <= adhp_pkg::ADHP_IDLE;
            wordPtr <= '0;
            dmaReq  <= 1'b0;
        end else begin
            case (mode)
                adhp_pkg::ADHP_IDLE: begin
                    if (cmdWr) begin
                        mode    <= dmaStart ? adhp_pkg::ADHP_DMA : adhp_pkg::ADHP_PIO;
                        dmaReq  <= dmaStart;
                        wordPtr <= '0;
                    end
                end
                adhp_pkg::ADHP_PIO, adhp_pkg::ADHP_DMA: begin
                    if (xferStep) begin
                        wordPtr <= wordPtr + 1'b1;
                        if (lastWord) begin
                            mode   <= adhp_pkg::ADHP_IDLE;
                            dmaReq <= 1'b0;
                        end
                    end
                end
                default: mode <= adhp_pkg::ADHP_IDLE;
            endcase
        end
    end

    // Sector store
    always_ff @(posedge clk) begin
        if (storeWord) begin
            sector[wordPtr] <= dataIn;
        end
    end

    always_ff @(posedge clk) begin
        if (anyReset) begin
            pendIrq <= 1'b0;
        end else if (xferStep && lastWord) begin
            pendIrq <= 1'b1;
        end else if (statusRd) begin
            pendIrq <= 1'b0;
        end
    end

    // Interrupt line
    always_ff @(posedge clk) begin
        if (reset) begin
            intReq <= 1'b0;
        end else begin
            intReq <= pendIrq && !devCtl[adhp_pkg::CTL_NIEN_BIT];
        end
    end

    // Word transfer indication
    always_ff @(posedge clk) begin
        if (reset) begin
            word16_n <= 1'b1;
        end else begin
            word16_n <= !(mode != adhp_pkg::ADHP_IDLE && dataAcc);
        end
    end

    // Disk active and slave present
    always_ff @(posedge clk) begin
        if (reset) begin
            diskActive_n_out <= 1'b1;
            diskActive_n_oe  <= 1'b0;
        end else begin
            diskActive_n_out <= 1'b0;
            diskActive_n_oe  <= (!isMaster && strapDone) || mode != adhp_pkg::ADHP_IDLE;
        end
    end

    // Bus drive enable
    always_ff @(posedge clk) begin
        if (reset) begin
            dataOe <= 1'b0;
        end else begin
            dataOe <= !ioRead_n && (dataAcc || tfSel || ctlSel);
        end
    end

    // Read data select
    always_ff @(posedge clk) begin
        if (reset) begin
            dataOut <= adhp_pkg::ZERO16;
        end else if (dataAcc && mode != adhp_pkg::ADHP_IDLE) begin
            dataOut <= sector[wordPtr];
        end else if (ctlSel) begin
            dataOut <= {8'h00, taskFile[adhp_pkg::ADDR_STATUS]};
        end else begin
            dataOut <= {8'h00, taskFile[devAddr]};
        end
    end
endmodule : adhp_host_port

// file: verification/adhp_sva.sv
`timescale 1ns/1ps
module adhp_sva (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       hostReset_n,
    input wire logic [2:0] devAddr,
    input wire logic       chipSel0_n,
    input wire logic       chipSel1_n,
    input wire logic       ioWrite_n,
    input wire logic       ioRead_n,
    input wire logic       dmaAck_n,
    input wire logic       cableSel,
    input wire logic       dmaStart,
    input wire logic       dataOe,
    input wire logic       dmaReq,
    input wire logic       intReq,
    input wire logic       diskActive_n_out,
    input wire logic       diskActive_n_oe,
    input wire logic       isMaster
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_oe_on_read: assert property (dataOe |-> $past(!ioRead_n && (!(chipSel0_n && chipSel1_n) || !dmaAck_n)))
        else $error("oe");
    a_oe_idle: assert property (ioRead_n && $past(ioRead_n) |-> !dataOe) else $error("oe idle");
    a_dma_cause: assert property ($rose(dmaReq) |-> $past(!chipSel0_n && devAddr == 3'h7 && dmaStart)) else $error("dma");
    a_irq_done: assert property ($fell(dmaReq) && $past(hostReset_n) |-> ##[0:2] intReq)
        else $error("irq done");
    a_irq_hold: assert property ($rose(intReq) && $past(ioRead_n && hostReset_n) |=> intReq)
        else $error("irq hold");
    a_irq_clear: assert property (intReq && !chipSel0_n && chipSel1_n && $fell(ioRead_n)
        && devAddr == adhp_pkg::ADDR_STATUS |-> ##[1:2] !intReq) else $error("irq clear");
    a_host_reset: assert property (!hostReset_n |=> !dmaReq ##1 !intReq) else $error("host reset");
    a_master_keep: assert property ($past(!reset, 3) && $stable(cableSel) |-> $stable(isMaster)) else $error("role");
    a_dasp_low: assert property (diskActive_n_oe |-> !diskActive_n_out) else $error("dasp");
    c_dma: cover property ($rose(dmaReq));
    c_irq: cover property ($rose(intReq));
    c_read: cover property (dataOe);
endmodule : adhp_sva
bind adhp_host_port adhp_sva u_sva (.clk, .reset, .hostReset_n, .devAddr, .chipSel0_n, .chipSel1_n, .ioWrite_n,
    .ioRead_n, .dmaAck_n, .cableSel, .dmaStart, .dataOe, .dmaReq, .intReq, .diskActive_n_out, .diskActive_n_oe,
    .isMaster);

// file: verification/adhp_host_model.sv
`timescale 1ns/1ps
module adhp_host_model (
    input  wire logic        clk,
    output logic             hostReset_n,
    output logic [2:0]       devAddr,
    output logic             chipSel0_n,
    output logic             chipSel1_n,
    output logic             ioWrite_n,
    output logic             ioRead_n,
    output logic             dmaAck_n,
    output logic [15:0]      dataIn,
    input  wire logic [15:0] dataOut
);
    initial begin
        {hostReset_n, chipSel0_n, chipSel1_n, ioWrite_n, ioRead_n, dmaAck_n} = 6'h3f;
        devAddr = 3'h0;
        dataIn = 16'hffff;
    end
    task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] d, input logic ack);
        @(posedge clk);
        {chipSel1_n, chipSel0_n, devAddr, dataIn, dmaAck_n} <= {cs, a, d, ack};
        ioWrite_n <= 1'b0;
        @(posedge clk);
        ioWrite_n <= 1'b1;
        @(posedge clk);
        {chipSel1_n, chipSel0_n, dmaAck_n} <= 3'h7;
        dataIn <= ~d;
    endtask : wr
    task automatic rd(input logic [1:0] cs, input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        {chipSel1_n, chipSel0_n, devAddr, ioRead_n} <= {cs, a, 1'b0};
        repeat (2) @(posedge clk);
        d = dataOut;
        ioRead_n <= 1'b1;
        @(posedge clk);
        {chipSel1_n, chipSel0_n} <= 2'h3;
    endtask : rd
    task automatic hard_reset(input int n);
        @(posedge clk);
        hostReset_n <= 1'b0;
        repeat (n) @(posedge clk);
        hostReset_n <= 1'b1;
    endtask : hard_reset
endmodule : adhp_host_model

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, reset = 1'b1, cableSel = 1'b0, dmaStart = 1'b0;
    logic        hostReset_n, chipSel0_n, chipSel1_n, ioWrite_n, ioRead_n, dmaAck_n, dataOe, dmaReq, intReq;
    logic        word16_n, diskActive_n_out, diskActive_n_oe, isMaster;
    logic [2:0]  devAddr;
    logic [15:0] dataIn, dataOut, rdat;
    int          error_cnt = 0, total_checks = 0;
    always #5 clk = ~clk;
    adhp_host_port dut (.clk, .reset, .hostReset_n, .devAddr, .chipSel0_n, .chipSel1_n, .ioWrite_n, .ioRead_n,
        .dmaAck_n, .cableSel, .dataIn, .dataOut, .dataOe, .dmaReq, .intReq, .word16_n, .diskActive_n_out,
        .diskActive_n_oe, .isMaster, .dmaStart, .dmaDir(1'b0));
    adhp_host_model host (.clk, .hostReset_n, .devAddr, .chipSel0_n, .chipSel1_n, .ioWrite_n, .ioRead_n,
        .dmaAck_n, .dataIn, .dataOut);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic do_reset(input logic cs);
        @(posedge clk);
        cableSel <= cs;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("isMaster", 16'(!cs), 16'(isMaster));
        chk("dasp oe", 16'(cs), 16'(diskActive_n_oe));
        chk("dasp out", 16'h0000, 16'(diskActive_n_out));
    endtask : do_reset
    task automatic test_sector(input logic dma);
        @(posedge clk);
        dmaStart <= dma;
        host.wr(2'h2, 3'h7, 16'h0030, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk("dmaReq", 16'(dma), 16'(dmaReq));
        for (int i = 0; i < adhp_pkg::SECTOR_WORDS; i++) begin
            if (i == adhp_pkg::SECTOR_WORDS - 1) chk("irq early", 16'h0000, 16'(intReq));
            host.wr(dma ? 2'h3 : 2'h2, 3'h0, 16'(i), !dma);
        end
        repeat (2) @(posedge clk);
        #1;
        chk("irq done", 16'h0001, 16'(intReq));
        chk("dmaReq off", 16'h0000, 16'(dmaReq));
    endtask : test_sector
    task automatic test_status();
        host.rd(2'h1, 3'h6, rdat);
        chk("alt status", 16'(adhp_pkg::STAT_RESET), 16'(rdat[7:0]));
        host.rd(2'h2, 3'h7, rdat);
        chk("status", 16'(adhp_pkg::STAT_RESET), 16'(rdat[7:0]));
        chk("irq clear", 16'h0000, 16'(intReq));
    endtask : test_status
    task automatic test_readback();
        @(posedge clk);
        dmaStart <= 1'b0;
        host.wr(2'h2, adhp_pkg::ADDR_STATUS, 16'h0020, 1'b1);
        for (int i = 0; i < adhp_pkg::SECTOR_WORDS; i++) begin
            host.rd(2'h2, adhp_pkg::ADDR_DATA, rdat);
            chk("read word", 16'(i), rdat);
            chk("word16_n", 16'h0000, 16'(word16_n));
            chk("dataOe", 16'h0001, 16'(dataOe));
        end
    endtask : test_readback
    task automatic test_host_reset();
        @(posedge clk);
        dmaStart <= 1'b1;
        host.wr(2'h2, adhp_pkg::ADDR_STATUS, 16'h00c8, 1'b1);
        host.wr(2'h3, adhp_pkg::ADDR_DATA, 16'h1234, 1'b0);
        chk("dmaReq armed", 16'h0001, 16'(dmaReq));
        host.hard_reset(2);
        @(posedge clk);
        #1;
        chk("dmaReq hreset", 16'h0000, 16'(dmaReq));
        chk("irq hreset", 16'h0000, 16'(intReq));
        host.rd(2'h2, adhp_pkg::ADDR_STATUS, rdat);
        chk("status hreset", 16'(adhp_pkg::STAT_RESET), 16'(rdat[7:0]));
    endtask : test_host_reset
    initial begin
        #100us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        do_reset(1'b0);
        test_sector(1'b0);
        test_status();
        test_sector(1'b1);
        test_readback();
        test_host_reset();
        do_reset(1'b1);
        report_and_stop();
    end
endmodule : testbench
